// ---- rtl/frac_mul.sv ----
// Purpose: signed 16x16 fractional multiply with doubling and saturation
// Assumes: requests arrive as single-cycle pulses with the predicate true
// Notes:   one delay slot: result appears two edges after the request
`timescale 1ns/10ps
module frac_mul (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic enable_i,
  shift_mpy_if.mul  m
);

  logic [31:0]                  prod_r,  prod_nxt;   // stage-one doubled product
  logic                         ovf_r,   ovf_nxt;    // stage-one overflow
  logic [31:0]                  res_r,   res_nxt;
  logic                         done_r,  done_nxt;
  logic                         sat_r,   sat_nxt;
  shift_mpy_pkg::mul_state_type st_r,    st_nxt;

  // pick a signed half per variant
  function automatic logic signed [15:0] half(input logic [31:0] w, input logic hi);
    half = hi ? w[31:16] : w[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // next state: stage one multiplies, stage two writes
  always_comb begin
    logic signed [15:0] a;
    logic signed [15:0] b;
    logic signed [31:0] p;
    logic [31:0]        d;
    a = half(m.src1, (m.op == shift_mpy_pkg::MUL_HL) || (m.op == shift_mpy_pkg::MUL_HH));
    b = half(m.src2, (m.op == shift_mpy_pkg::MUL_LH) || (m.op == shift_mpy_pkg::MUL_HH));
    p = a * b;
    d = {p[30:0], 1'b0};
    prod_nxt = prod_r;
    ovf_nxt  = ovf_r;
    res_nxt  = res_r;
    done_nxt = 1'b0;
    sat_nxt  = 1'b0;
    st_nxt   = st_r;
    case (st_r)
      shift_mpy_pkg::MUL_IDLE, shift_mpy_pkg::MUL_WROTE: begin
        st_nxt = shift_mpy_pkg::MUL_IDLE;
      end
      shift_mpy_pkg::MUL_BUSY: begin
        // second edge writes: one delay slot
        res_nxt  = ovf_r ? shift_mpy_pkg::MOST_POS : prod_r;
        done_nxt = 1'b1;
        sat_nxt  = ovf_r;
        st_nxt   = shift_mpy_pkg::MUL_WROTE;
      end
      default: st_nxt = shift_mpy_pkg::MUL_IDLE;
    endcase
    // back-to-back issue is allowed, the pipe accepts each cycle
    if (m.req) begin
      prod_nxt = d;
      ovf_nxt  = (d == shift_mpy_pkg::MOST_NEG);
      st_nxt   = shift_mpy_pkg::MUL_BUSY;
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prod_r <= 32'h00000000;
      ovf_r  <= 1'b0;
      res_r  <= 32'h00000000;
      done_r <= 1'b0;
      sat_r  <= 1'b0;
      st_r   <= shift_mpy_pkg::MUL_IDLE;
    end else if (enable_i) begin
      prod_r <= prod_nxt;
      ovf_r  <= ovf_nxt;
      res_r  <= res_nxt;
      done_r <= done_nxt;
      sat_r  <= sat_nxt;
      st_r   <= st_nxt;
    end
  end

  assign m.res  = res_r;
  assign m.done = done_r;
  assign m.saturation_flag  = sat_r;

  a_mul_sat_value: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    m.done && m.saturation_flag |-> m.res == shift_mpy_pkg::MOST_POS)
    else $error("saturated result is not the most positive value");

endmodule

// ---- rtl/shift_mpy_if.sv ----
// Purpose: carries one multiply request from the datapath top to the multiplier
// Assumes: single clock, request valid for one cycle
// Notes:   none
`timescale 1ns/10ps
interface shift_mpy_if;
  logic        req;   // issue pulse, predicate already true
  logic [4:0]  op;    // multiply opfield
  logic [31:0] src1;  // first source word
  logic [31:0] src2;  // second source word
  logic        done;  // result write pulse
  logic [31:0] res;   // written result
  logic        saturation_flag;   // saturation happened on this result

  modport top (output req, output op, output src1, output src2, input done, input res, input saturation_flag);
  modport mul (input req, input op, input src1, input src2, output done, output res, output saturation_flag);
endinterface

// ---- rtl/shift_mpy_pkg.sv ----
// Purpose: shared constants and types for the shift and fractional multiply datapath
// Assumes: core clock domain only
// Notes:   opfield codes are the instruction encodings handed over by decode
package shift_mpy_pkg;

  // shift opfields (6 bits)
  localparam logic [5:0] LSR_REG_32 = 6'h27;  // 100111 word, register amount
  localparam logic [5:0] LSR_REG_40 = 6'h25;  // 100101 long, register amount
  localparam logic [5:0] LSR_IMM_32 = 6'h26;  // 100110 word, immediate amount
  localparam logic [5:0] LSR_IMM_40 = 6'h24;  // 100100 long, immediate amount

  // multiply opfields (5 bits)
  localparam logic [4:0] MUL_LL = 5'h1a;  // 11010 low x low
  localparam logic [4:0] MUL_HL = 5'h0a;  // 01010 high x low
  localparam logic [4:0] MUL_LH = 5'h12;  // 10010 low x high
  localparam logic [4:0] MUL_HH = 5'h02;  // 00010 high x high

  localparam int          AMT_BITS     = 6;            // register amount bits used
  localparam logic [5:0]  AMT_CLAMP_LO = 6'h27;        // amounts above 39 clamp
  localparam logic [5:0]  AMT_CLAMP    = 6'h28;        // clamp amount 40
  localparam logic [31:0] MOST_NEG     = 32'h80000000; // doubled product overflow
  localparam logic [31:0] MOST_POS     = 32'h7fffffff; // replacement value
  localparam logic [39:0] RES_RESET    = 40'h0000000000;

  // multiply pipeline stage
  typedef enum logic [1:0] {
    MUL_IDLE  = 2'b00,
    MUL_BUSY  = 2'b01,
    MUL_WROTE = 2'b10
  } mul_state_type;

endpackage

// ---- rtl/shift_right_and_fractional_mpy.sv ----
// Purpose: logical right shift unit and fractional multiply unit of the core datapath
// Assumes: decode presents one predicated request per unit per cycle on the core clock
// Notes:   shift result is written at the issue edge, multiply after one delay slot
`timescale 1ns/10ps

module shift_right_and_fractional_mpy (
  input  wire logic        clk_i,         // core clock
  input  wire logic        reset_n_i,     // async reset, active low
  input  wire logic        enable_i,      // clock enable, freezes all state
  input  wire logic        shift_req_i,   // shift issue pulse
  input  wire logic        shift_pred_i,  // predicate true
  input  wire logic [5:0]  shift_op_i,    // shift opfield
  input  wire logic [31:0] shift_src1_i,  // amount register or immediate in low bits
  input  wire logic [39:0] shift_src2_i,  // operand, word forms use low 32 bits
  input  wire logic        mul_req_i,     // multiply issue pulse
  input  wire logic        mul_pred_i,    // predicate true
  input  wire logic [4:0]  mul_op_i,      // multiply opfield
  input  wire logic [31:0] mul_src1_i,    // first source
  input  wire logic [31:0] mul_src2_i,    // second source
  input  wire logic        sat_clear_i,   // control status write clears flag
  output logic             shift_wr_o,    // shift destination write pulse
  output logic [39:0]      shift_res_o,   // shift result
  output logic             mul_wr_o,      // multiply destination write pulse
  output logic [31:0]      mul_res_o,     // multiply result
  output logic             saturation_flag_o // sticky saturation bit
);

  logic [39:0] sres_r, sres_nxt;  // shift result
  logic        swr_r,  swr_nxt;   // shift write strobe
  logic        sat_r,  sat_nxt;   // sticky flag

  shift_mpy_if mif ();

  ////////////////////////////////////////////////////////////////
  // amount decode: register forms clamp, immediate forms take 5 bits
  function automatic logic [5:0] shift_amt(input logic [5:0] op, input logic [31:0] s1);
    logic [5:0] a;
    a = s1[5:0];
    if (op == shift_mpy_pkg::LSR_IMM_32 || op == shift_mpy_pkg::LSR_IMM_40) begin
      shift_amt = {1'b0, s1[4:0]};
    end else if (a > shift_mpy_pkg::AMT_CLAMP_LO) begin
      shift_amt = shift_mpy_pkg::AMT_CLAMP;
    end else begin
      shift_amt = a;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // shift next values: result lands at the issue edge, no delay slot
  always_comb begin
    logic [39:0] opnd;
    logic        wide;
    wide     = (shift_op_i == shift_mpy_pkg::LSR_REG_40) || (shift_op_i == shift_mpy_pkg::LSR_IMM_40);
    opnd     = wide ? shift_src2_i : {8'h00, shift_src2_i[31:0]};
    sres_nxt = sres_r;
    swr_nxt  = 1'b0;
    if (shift_req_i && shift_pred_i) begin
      // logical shift: zero fill, 40 clears a long fully
      sres_nxt = opnd >> shift_amt(shift_op_i, shift_src1_i);
      swr_nxt  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // multiply issue: a false predicate never enters the pipe
  assign mif.req  = mul_req_i && mul_pred_i;
  assign mif.op   = mul_op_i;
  assign mif.src1 = mul_src1_i;
  assign mif.src2 = mul_src2_i;

  frac_mul u_mul (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .enable_i  (enable_i),
    .m         (mif.mul)
  );

  ////////////////////////////////////////////////////////////////
  // sticky flag: set one edge after the write, set beats clear
  always_comb begin
    sat_nxt = sat_r;
    if (sat_clear_i) begin
      sat_nxt = 1'b0;
    end
    if (mif.done && mif.saturation_flag) begin
      sat_nxt = 1'b1;
    end
  end

  // result registers only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sres_r <= shift_mpy_pkg::RES_RESET;
      swr_r  <= 1'b0;
      sat_r  <= 1'b0;
    end else if (enable_i) begin
      sres_r <= sres_nxt;
      swr_r  <= swr_nxt;
      sat_r  <= sat_nxt;
    end
  end

  // outputs straight from flip-flops
  assign shift_res_o       = sres_r;
  assign shift_wr_o        = swr_r;
  assign mul_res_o         = mif.res;
  assign mul_wr_o          = mif.done;
  assign saturation_flag_o = sat_r;

  ////////////////////////////////////////////////////////////////
  a_flag_after_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && mul_wr_o && mif.saturation_flag && enable_i |=> saturation_flag_o)
    else $error("saturation flag not set after saturated write");

  a_mul_one_slot: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && mul_req_i && mul_pred_i ##1 enable_i |=> mul_wr_o)
    else $error("multiply result not written after one delay slot");

  a_shift_no_slot: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && shift_req_i && shift_pred_i |=> shift_wr_o)
    else $error("shift result not written at issue edge");

  a_pred_false_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && !(shift_req_i && shift_pred_i) |=> !shift_wr_o && $stable(shift_res_o))
    else $error("shift destination changed without true predicate");

  a_clamp_forty: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && shift_req_i && shift_pred_i && shift_op_i == shift_mpy_pkg::LSR_REG_40
      && shift_src1_i[5:0] > 6'h27 |=> shift_res_o == 40'h0000000000)
    else $error("clamped long shift left bits behind");

  a_zero_fill: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && shift_req_i && shift_pred_i && shift_op_i == shift_mpy_pkg::LSR_IMM_32
      && shift_src1_i[4:0] != 5'h00 |=> shift_res_o[39:31] == 9'h000)
    else $error("word shift did not zero fill");

  a_high_bits_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && shift_req_i && shift_pred_i && shift_op_i == shift_mpy_pkg::LSR_REG_32
      |=> shift_res_o == ({8'h00, $past(shift_src2_i[31:0])} >> $past(shift_src1_i[5:0])))
    else $error("word register shift used amount bits above five");

  a_imm_amount: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    enable_i && shift_req_i && shift_pred_i && shift_op_i == shift_mpy_pkg::LSR_IMM_40
      |=> shift_res_o == ($past(shift_src2_i) >> $past(shift_src1_i[4:0])))
    else $error("immediate shift amount wrong");

endmodule

// ---- tb/decode_model.sv ----
// Purpose: stands in for decode and pipeline control, issuing one predicated request per task call
// Assumes: requests change at the falling edge, so the rising edge samples them settled
// Notes:   each request is a one-cycle pulse; the qualifiers drop to zero with it
`timescale 1ns/10ps
module decode_model (
  input  wire logic  clk_i,        // core clock
  output logic       shift_req_o,  // shift issue pulse
  output logic       shift_pred_o, // shift predicate
  output logic [5:0] shift_op_o,   // shift opfield
  output logic [31:0] shift_a_o,   // amount source
  output logic [39:0] shift_b_o,   // operand source
  output logic       mul_req_o,    // multiply issue pulse
  output logic       mul_pred_o,   // multiply predicate
  output logic [4:0] mul_op_o,     // multiply opfield
  output logic [31:0] mul_a_o,     // first multiply source
  output logic [31:0] mul_b_o      // second multiply source
);
  initial begin
    {shift_req_o, shift_pred_o, shift_op_o, shift_a_o, shift_b_o} = '0;
    {mul_req_o, mul_pred_o, mul_op_o, mul_a_o, mul_b_o} = '0;
  end
  // one shift issue; returns at the falling edge after the taking edge
  task automatic shift(input logic p, input logic [5:0] op, input logic [31:0] a, input logic [39:0] b);
    @(negedge clk_i);
    {shift_req_o, shift_pred_o, shift_op_o, shift_a_o, shift_b_o} = {1'b1, p, op, a, b};
    @(negedge clk_i);
    {shift_req_o, shift_pred_o, shift_op_o, shift_a_o, shift_b_o} = '0;
  endtask
  // one multiply issue; same pulse shape as the shift
  task automatic mul(input logic p, input logic [4:0] op, input logic [31:0] a, input logic [31:0] b);
    @(negedge clk_i);
    {mul_req_o, mul_pred_o, mul_op_o, mul_a_o, mul_b_o} = {1'b1, p, op, a, b};
    @(negedge clk_i);
    {mul_req_o, mul_pred_o, mul_op_o, mul_a_o, mul_b_o} = '0;
  endtask
endmodule

// ---- tb/shift_right_and_fractional_mpy_tb.sv ----
// Purpose: self-checking bench for the shift and fractional multiply datapath
// Assumes: fixed latencies of one cycle for the shift and two for the multiply
// Notes:   expected values are computed here from the operand fields
`timescale 1ns/10ps
module shift_right_and_fractional_mpy_tb;
  logic clk_i = 1'b0;         // core clock
  logic reset_n_i = 1'b0;     // async reset, active low
  logic sat_clear_i = 1'b0;   // flag clear
  logic enable = 1'b1;        // clock enable
  logic shift_req, shift_pred, mul_req, mul_pred;
  logic [5:0] shift_op;
  logic [4:0] mul_op;
  logic [31:0] shift_a, mul_a, mul_b, mul_res;
  logic [39:0] shift_b, shift_res;
  logic shift_wr, mul_wr, sat_flag;
  int failures = 0;           // mismatch count
  int total_checks = 0;       // comparison count
  always #5 clk_i = ~clk_i;
  decode_model drv (.clk_i(clk_i), .shift_req_o(shift_req), .shift_pred_o(shift_pred), .shift_op_o(shift_op),
    .shift_a_o(shift_a), .shift_b_o(shift_b), .mul_req_o(mul_req), .mul_pred_o(mul_pred), .mul_op_o(mul_op),
    .mul_a_o(mul_a), .mul_b_o(mul_b));
  shift_right_and_fractional_mpy uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable),
    .shift_req_i(shift_req), .shift_pred_i(shift_pred), .shift_op_i(shift_op), .shift_src1_i(shift_a),
    .shift_src2_i(shift_b), .mul_req_i(mul_req), .mul_pred_i(mul_pred), .mul_op_i(mul_op), .mul_src1_i(mul_a),
    .mul_src2_i(mul_b), .sat_clear_i(sat_clear_i), .shift_wr_o(shift_wr), .shift_res_o(shift_res),
    .mul_wr_o(mul_wr), .mul_res_o(mul_res), .saturation_flag_o(sat_flag));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_bit(input string n, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic cmp_val(input string n, input logic [39:0] e, input logic [39:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one shift with its own expectation; amounts above 39 clamp, imm uses five bits
  task automatic one_shift(input logic [5:0] op, input logic [31:0] a, input logic [39:0] b);
    logic [5:0] amt;
    logic [39:0] opnd;
    // immediate forms have opfield bit 0 clear, register forms set
    if (op == shift_mpy_pkg::LSR_IMM_32 || op == shift_mpy_pkg::LSR_IMM_40) begin
      amt = {1'b0, a[4:0]};
    end else begin
      amt = (a[5:0] > 6'h27) ? 6'h28 : a[5:0];
    end
    opnd = (op[1:0] == 2'b10 || op[1:0] == 2'b11) ? {8'h00, b[31:0]} : b;
    drv.shift(1'b1, op, a, b);
    cmp_bit("shift_wr", 1'b1, shift_wr);
    cmp_val("shift_res", opnd >> amt, shift_res);
    @(negedge clk_i);
    cmp_bit("shift_wr_end", 1'b0, shift_wr);
  endtask
  task automatic test_shifts();
    one_shift(shift_mpy_pkg::LSR_REG_32, 32'h00000008, 40'hff_f1234567);
    one_shift(shift_mpy_pkg::LSR_REG_40, 32'h0000002d, 40'hff_ffffffff);
    one_shift(shift_mpy_pkg::LSR_REG_40, 32'hffffffc7, 40'h80_00000000);
    one_shift(shift_mpy_pkg::LSR_REG_40, 32'h00000027, 40'hff_00000000);
    one_shift(shift_mpy_pkg::LSR_IMM_32, 32'h000000ff, 40'h00_ffffffff);
    one_shift(shift_mpy_pkg::LSR_IMM_40, 32'h00000004, 40'hab_cdef0123);
    one_shift(shift_mpy_pkg::LSR_REG_32, 32'h00000000, 40'h12_87654321);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one multiply: write two edges after issue, saturation flag one cycle later
  task automatic one_mul(input logic [4:0] op, input logic [31:0] a, input logic [31:0] b);
    logic signed [15:0] ha, hb;
    logic [31:0] p;
    logic signed [31:0] full;
    ha = (op == shift_mpy_pkg::MUL_HL || op == shift_mpy_pkg::MUL_HH) ? a[31:16] : a[15:0];
    hb = (op == shift_mpy_pkg::MUL_LH || op == shift_mpy_pkg::MUL_HH) ? b[31:16] : b[15:0];
    full = ha * hb;  // signed 32-bit product, then doubled
    p = {full[30:0], 1'b0};
    drv.mul(1'b1, op, a, b);
    cmp_bit("mul_wr_slot", 1'b0, mul_wr);
    @(negedge clk_i);
    cmp_bit("mul_wr", 1'b1, mul_wr);
    cmp_val("mul_res", {8'h00, (p == 32'h80000000) ? 32'h7fffffff : p}, {8'h00, mul_res});
    cmp_bit("sat_before", 1'b0, sat_flag);
    @(negedge clk_i);
    cmp_bit("sat_flag", p == 32'h80000000, sat_flag);
  endtask
  task automatic clear_flag();
    @(negedge clk_i);
    sat_clear_i = 1'b1;
    @(negedge clk_i);
    sat_clear_i = 1'b0;
  endtask
  task automatic test_muls();
    one_mul(shift_mpy_pkg::MUL_LL, 32'h00000123, 32'h01e0fa81);
    one_mul(shift_mpy_pkg::MUL_HL, 32'hfff30000, 32'h00007fff);
    one_mul(shift_mpy_pkg::MUL_LH, 32'h00008000, 32'h7fff0000);
    one_mul(shift_mpy_pkg::MUL_HH, 32'h80000000, 32'h80000000);
    clear_flag();
    one_mul(shift_mpy_pkg::MUL_LL, 32'h00008000, 32'h00008000);
    clear_flag();
    cmp_bit("sat_cleared", 1'b0, sat_flag);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // false predicate: no write pulse, results and flag hold
  task automatic test_pred_false();
    logic [39:0] sr;
    logic [31:0] mr;
    sr = shift_res;
    mr = mul_res;
    drv.shift(1'b0, shift_mpy_pkg::LSR_REG_40, 32'h00000001, 40'hff_ffffffff);
    cmp_bit("shift_wr_nop", 1'b0, shift_wr);
    drv.mul(1'b0, shift_mpy_pkg::MUL_HH, 32'h80000000, 32'h80000000);
    repeat (2) @(negedge clk_i);
    cmp_bit("mul_wr_nop", 1'b0, mul_wr);
    cmp_bit("sat_nop", 1'b0, sat_flag);
    cmp_val("shift_hold", sr, shift_res);
    cmp_val("mul_hold", {8'h00, mr}, {8'h00, mul_res});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // enable low: requests are not taken and nothing moves
  task automatic test_enable_low();
    logic [39:0] sr;
    sr = shift_res;
    @(negedge clk_i);
    enable = 1'b0;
    drv.shift(1'b1, shift_mpy_pkg::LSR_REG_32, 32'h00000004, 40'hff_ffffffff);
    cmp_bit("shift_wr_frozen", 1'b0, shift_wr);
    cmp_val("shift_res_frozen", sr, shift_res);
    drv.mul(1'b1, shift_mpy_pkg::MUL_HH, 32'h80000000, 32'h80000000);
    repeat (2) @(negedge clk_i);
    cmp_bit("mul_wr_frozen", 1'b0, mul_wr);
    cmp_bit("sat_frozen", 1'b0, sat_flag);
    enable = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    test_shifts();
    test_muls();
    test_pred_false();
    test_enable_low();
    finish_test();
  end
  // watchdog cuts a hang short
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule
